// >>> cwr_top.sv
// clock watchdog, periodic timer and monitor control with wishbone slave
// What this block does
// - bus clocks divided by two to the slow divisor; zero bypasses
// - slow divider applies only in wait mode
// - periodic request when flag set and enable one
// - stop-in-wait halts periodic timer and watchdog in wait; write-once normal
// - stop-in-debug halts both in debug; write-once normal, free special
// - bypass test bit special only; periodic chain then divides by four
// - rate zero off; codes one to seven divide by 2^13..2^19
// - flag set at period end; software writes one to clear
// - monitor enable arms clock reset; ignored while forced enable set
// - forced enable write-once normal, free special; set in normal, holds monitor on until reset
// - force-monitor-reset special only, if enabled, blocked by suppression
// - force-watchdog-reset special only, if enabled, blocked by suppression
// - suppression blocks all watchdog and monitor resets; special only
// - watchdog rate write-once normal; codes select 2^13..2^23
// - bypass skips all but last two prescaler stages
// - service writes 0x55 then 0xaa; address reads zero
// - any other byte to service address resets at once
// - expiry without service starts system reset
`timescale 1ns/1ps
`default_nettype none
module cwr_top
  import cwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic specialMode,
  input wire logic waitMode,
  input wire logic debugActive,
  input wire logic clockFail,
  output logic busClkEn,
  output logic periodicInterrupt,
  output logic watchdogReset,
  output logic monitorReset,
  output logic monitorActive
);
  // pin synchronisers
  logic [1:0] specSync, waitSync, dbgSync, failSync;
  logic specM, waitM, dbgM, failM;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      specSync <= 2'h0;
      waitSync <= 2'h0;
      dbgSync <= 2'h0;
      failSync <= 2'h0;
    end else begin
      specSync <= {specSync[0], specialMode};
      waitSync <= {waitSync[0], waitMode};
      dbgSync <= {dbgSync[0], debugActive};
      failSync <= {failSync[0], clockFail};
    end
  end
  assign specM = specSync[1];
  assign waitM = waitSync[1];
  assign dbgM = dbgSync[1];
  assign failM = failSync[1];

  // registers and state
  logic [7:0] picReg, wmcReg, slowReg;
  logic [7:0] next_picReg, next_wmcReg, next_slowReg;
  logic flag, next_flag;
  logic picWritten, next_picWritten;
  logic wmcWritten, next_wmcWritten;
  cwr_seq_t seqState, next_seqState;
  logic [CWR_CHAIN_BITS-1:0] rtiCnt, next_rtiCnt;
  logic [CWR_CHAIN_BITS-1:0] wdCnt, next_wdCnt;
  logic next_ack;
  logic [31:0] next_dat;
  logic next_wdRst, next_monRst;
  cwr_req_t req;

  function automatic logic [CWR_CHAIN_BITS-1:0] bitMask(input logic [4:0] n);
    bitMask = CWR_CHAIN_BITS'(({25'h0, 1'b1} << n) - 26'h1);
  endfunction

  cwr_slow_div u_slow (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .slowDivisor(slowReg[2:0]),
    .waitMode(waitM),
    .busClkEn(busClkEn)
  );

  assign req.idx = wb_adr_i[5:2];
  assign req.we = wb_we_i;
  assign req.wdata = wb_dat_i[7:0];

  logic access, wrStb;
  logic timersRun;
  logic [4:0] rtiBits, wdBits;
  logic preBits;
  logic rtiTick, wdTick;
  logic monEnabled, wdEnabled;

  always_comb begin
    access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wrStb = access && req.we && wb_sel_i[0];
    timersRun = busClkEn && !(waitM && picReg[CWR_PIC_SW]) && !(dbgM && picReg[CWR_PIC_SD]);
    preBits = picReg[CWR_PIC_BYP];
    rtiBits = preBits ? 5'(CWR_PRE_BYP_BITS + picReg[2:0] - 3'h1)
                      : 5'(CWR_PRE_BITS - 1 + picReg[2:0]);
    case (wmcReg[2:0])
      3'h1: wdBits = 5'd0;
      3'h2: wdBits = 5'd2;
      3'h3: wdBits = 5'd4;
      3'h4: wdBits = 5'd6;
      3'h5: wdBits = 5'd8;
      3'h6: wdBits = 5'd9;
      3'h7: wdBits = 5'd10;
      default: wdBits = 5'd0;
    endcase
    wdBits = 5'(wdBits + (preBits ? CWR_PRE_BYP_BITS : CWR_PRE_BITS));
    rtiTick = (picReg[2:0] != 3'h0) && ((rtiCnt & bitMask(rtiBits)) == bitMask(rtiBits));
    wdEnabled = wmcReg[2:0] != 3'h0;
    wdTick = wdEnabled && ((wdCnt & bitMask(wdBits)) == bitMask(wdBits));
    monEnabled = wmcReg[CWR_WMC_FME] || wmcReg[CWR_WMC_ME];
  end

  always_comb begin
    next_picReg = picReg;
    next_wmcReg = wmcReg;
    next_slowReg = slowReg;
    next_flag = flag;
    next_picWritten = picWritten;
    next_wmcWritten = wmcWritten;
    next_seqState = seqState;
    next_rtiCnt = rtiCnt;
    next_wdCnt = wdCnt;
    next_ack = access;
    next_dat = 32'h0;
    next_wdRst = 1'b0;
    next_monRst = 1'b0;
    if (access && !req.we) begin
      case (req.idx)
        CWR_IDX_PIC: next_dat = {24'h0, picReg};
        CWR_IDX_PIF: next_dat = {24'h0, flag, 7'h00};
        CWR_IDX_WMC: next_dat = {24'h0, wmcReg};
        CWR_IDX_WSV: next_dat = 32'h0;
        CWR_IDX_SLOW: next_dat = {29'h0, slowReg[2:0]};
        CWR_IDX_STAT: next_dat = {28'h0, monEnabled, seqState == CWR_SEQ_ARMED, timersRun, specM};
        default: next_dat = 32'h0;
      endcase
    end
    if (timersRun) begin
      next_rtiCnt = (picReg[2:0] == 3'h0) ? '0 : CWR_CHAIN_BITS'(rtiCnt + 1'b1);
      next_wdCnt = wdEnabled ? CWR_CHAIN_BITS'(wdCnt + 1'b1) : '0;
      if (rtiTick) begin
        next_rtiCnt = '0;
      end
      if (wdTick) begin
        next_wdRst = 1'b1;
      end
    end
    if (wrStb) begin
      case (req.idx)
        CWR_IDX_PIC: begin
          next_picReg[CWR_PIC_IE] = req.wdata[CWR_PIC_IE];
          next_picReg[2:0] = req.wdata[2:0];
          if (specM || !picWritten) begin
            next_picReg[CWR_PIC_SW] = req.wdata[CWR_PIC_SW];
            next_picReg[CWR_PIC_SD] = req.wdata[CWR_PIC_SD];
          end
          if (specM) begin
            next_picReg[CWR_PIC_BYP] = req.wdata[CWR_PIC_BYP];
          end
          // only a normal-mode write uses up the single write
          next_picWritten = picWritten || !specM;
        end
        CWR_IDX_PIF: if (req.wdata[CWR_PIF_FLAG]) next_flag = 1'b0;
        CWR_IDX_WMC: begin
          next_wmcReg[CWR_WMC_ME] = req.wdata[CWR_WMC_ME];
          if (specM || !wmcWritten) begin
            next_wmcReg[CWR_WMC_FME] = req.wdata[CWR_WMC_FME];
            next_wmcReg[2:0] = req.wdata[2:0];
          end
          if (specM) begin
            next_wmcReg[CWR_WMC_RS] = req.wdata[CWR_WMC_RS];
            next_monRst = req.wdata[CWR_WMC_FMR] && monEnabled;
            next_wdRst = next_wdRst || (req.wdata[CWR_WMC_FWR] && wdEnabled);
          end
          // only a normal-mode write uses up the single write
          next_wmcWritten = wmcWritten || !specM;
        end
        CWR_IDX_WSV: begin
          if (req.wdata == CWR_SEQ_FIRST) begin
            next_seqState = CWR_SEQ_ARMED;
          end else if (req.wdata == CWR_SEQ_SECOND) begin
            if (seqState == CWR_SEQ_ARMED) begin
              next_wdCnt = '0;
              next_wdRst = 1'b0;
            end
            next_seqState = CWR_SEQ_IDLE;
          end else begin
            next_wdRst = 1'b1;
            next_seqState = CWR_SEQ_IDLE;
          end
        end
        CWR_IDX_SLOW: next_slowReg = {5'h00, req.wdata[2:0]};
        default: ;
      endcase
    end
    if (timersRun && rtiTick) begin
      next_flag = 1'b1;
    end
    if (failM && monEnabled) begin
      next_monRst = 1'b1;
    end
    if (wmcReg[CWR_WMC_RS]) begin
      next_wdRst = 1'b0;
      next_monRst = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      picReg <= CWR_PIC_RST;
      wmcReg <= CWR_WMC_RST;
      slowReg <= CWR_SLOW_RST;
      flag <= 1'b0;
      picWritten <= 1'b0;
      wmcWritten <= 1'b0;
      seqState <= CWR_SEQ_IDLE;
      rtiCnt <= '0;
      wdCnt <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      watchdogReset <= 1'b0;
      monitorReset <= 1'b0;
    end else begin
      picReg <= next_picReg;
      wmcReg <= next_wmcReg;
      slowReg <= next_slowReg;
      flag <= next_flag;
      picWritten <= next_picWritten;
      wmcWritten <= next_wmcWritten;
      seqState <= next_seqState;
      rtiCnt <= next_rtiCnt;
      wdCnt <= next_wdCnt;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      watchdogReset <= next_wdRst;
      monitorReset <= next_monRst;
    end
  end

  assign periodicInterrupt = flag && picReg[CWR_PIC_IE];
  assign monitorActive = monEnabled;
endmodule
`default_nettype wire

// >>> cwr_pkg.sv
// shared constants and types for the clock watchdog / periodic timer block
package cwr_pkg;
  // register word addresses (byte address = 4 * index)
  localparam logic [3:0] CWR_IDX_PIC = 4'h0;
  localparam logic [3:0] CWR_IDX_PIF = 4'h1;
  localparam logic [3:0] CWR_IDX_WMC = 4'h2;
  localparam logic [3:0] CWR_IDX_WSV = 4'h3;
  localparam logic [3:0] CWR_IDX_SLOW = 4'h4;
  localparam logic [3:0] CWR_IDX_STAT = 4'h5;
  // periodic_irq_control fields
  localparam int CWR_PIC_IE = 7;
  localparam int CWR_PIC_SW = 6;
  localparam int CWR_PIC_SD = 5;
  localparam int CWR_PIC_BYP = 3;
  // periodic_irq_flag field
  localparam int CWR_PIF_FLAG = 7;
  // watchdog_monitor_control fields
  localparam int CWR_WMC_ME = 7;
  localparam int CWR_WMC_FME = 6;
  localparam int CWR_WMC_FMR = 5;
  localparam int CWR_WMC_FWR = 4;
  localparam int CWR_WMC_RS = 3;
  // reset values
  localparam logic [7:0] CWR_PIC_RST = 8'h00;
  localparam logic [7:0] CWR_WMC_RST = 8'h01;
  localparam logic [7:0] CWR_SLOW_RST = 8'h00;
  // service sequence bytes
  localparam logic [7:0] CWR_SEQ_FIRST = 8'h55;
  localparam logic [7:0] CWR_SEQ_SECOND = 8'haa;
  // prescaler widths (E divided by 2^13, bypass leaves 2 stages)
  localparam int CWR_PRE_BITS = 13;
  localparam int CWR_PRE_BYP_BITS = 2;
  localparam int CWR_CHAIN_BITS = 24;
  // service sequence state
  typedef enum logic {CWR_SEQ_IDLE, CWR_SEQ_ARMED} cwr_seq_t;
  // bus request carrier
  typedef struct packed {
    logic [3:0] idx;
    logic we;
    logic [7:0] wdata;
  } cwr_req_t;
endpackage

// >>> cwr_slow_div.sv
// wait-mode slow clock divider producing a bus clock enable
`timescale 1ns/1ps
`default_nettype none
module cwr_slow_div
  import cwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] slowDivisor,
  input wire logic waitMode,
  output logic busClkEn
);
  logic [6:0] divCnt;
  logic [6:0] next_divCnt;
  logic [6:0] divMask;

  always_comb begin
    divMask = 7'(({7'h00, 1'b1} << slowDivisor) - 8'h01);
    next_divCnt = 7'h00;
    busClkEn = 1'b1;
    if (waitMode && slowDivisor != 3'h0) begin
      busClkEn = ((divCnt & divMask) == divMask);
      next_divCnt = 7'(divCnt + 7'h01);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 7'h00;
    end else begin
      divCnt <= next_divCnt;
    end
  end
endmodule
`default_nettype wire

// >>> cwr_top_props.sv
// concurrent checks on the ports of the clock watchdog block
`timescale 1ns/1ps
`default_nettype none
module cwr_top_props
  import cwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic specialMode,
  input wire logic waitMode,
  input wire logic debugActive,
  input wire logic clockFail,
  input wire logic busClkEn,
  input wire logic periodicInterrupt,
  input wire logic watchdogReset,
  input wire logic monitorReset,
  input wire logic monitorActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic rdAck = wb_ack_o && !wb_we_i;
  wire logic [3:0] idx = wb_adr_i[5:2];
  property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_rst_out; $rose(resetn) |-> !wb_ack_o && !watchdogReset && busClkEn; endproperty
  a_rst_out: assert property (p_rst_out) else $error("bad reset outputs");
  property p_svc_zero; rdAck && idx == CWR_IDX_WSV |-> wb_dat_o == 32'h0; endproperty
  a_svc_zero: assert property (p_svc_zero) else $error("service read not zero");
  property p_unmapped; rdAck && idx > CWR_IDX_STAT |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_en; rdAck && idx == CWR_IDX_PIC && !wb_dat_o[CWR_PIC_IE] |-> !periodicInterrupt;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("request while disabled");
  property p_mon_read;
    rdAck && idx == CWR_IDX_WMC |-> monitorActive == (wb_dat_o[CWR_WMC_ME] | wb_dat_o[CWR_WMC_FME]);
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("monitor state wrong");
  property p_mon_cause; monitorReset |-> $past(monitorActive); endproperty
  a_mon_cause: assert property (p_mon_cause) else $error("monitor reset unarmed");
  property p_no_wait_div; (!waitMode) [*4] |-> busClkEn; endproperty
  a_no_wait_div: assert property (p_no_wait_div) else $error("bus slowed outside wait");
  c_irq: cover property (periodicInterrupt);
  c_wdog: cover property (watchdogReset);
  c_mon: cover property (monitorReset);
endmodule
bind cwr_top cwr_top_props i_cwr_top_props (.*);
`default_nettype wire

// >>> cwr_top_tb.sv
// self-checking bench for the clock watchdog block
`timescale 1ns/1ps
`default_nettype none
module cwr_top_tb;
  import cwr_pkg::*;
  logic ref_clk, resetn, wbCyc, wbStb, wbWe, specialMode, waitMode, debugActive, clockFail;
  logic [5:0] wbAdr;
  logic [31:0] wbDat, wbDatO, q32;
  logic wbAck, busClkEn, periodicInterrupt, watchdogReset, monitorReset, monitorActive;
  logic [7:0] b;
  int fails, cmpCount, wdCnt, mrCnt, n, s, wdBase, mrBase;
  cwr_top i_cwr_top (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .specialMode(specialMode), .waitMode(waitMode),
    .debugActive(debugActive), .clockFail(clockFail), .busClkEn(busClkEn),
    .periodicInterrupt(periodicInterrupt), .watchdogReset(watchdogReset),
    .monitorReset(monitorReset), .monitorActive(monitorActive));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    wdCnt <= wdCnt + int'(watchdogReset === 1'b1);
    mrCnt <= mrCnt + int'(monitorReset === 1'b1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d);
    int t;
    t = 0;
    // pulses caused by this access are counted from here on
    wdBase = wdCnt;
    mrBase = mrCnt;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {i, 2'b00};
    wbDat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      t++;
    end while (wbAck !== 1'b1 && t < 40);
    if (t >= 40) fails++;
    q32 = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q32, {24'h0, e});
  endtask
  task automatic svc;
    wb(1'b1, CWR_IDX_WSV, CWR_SEQ_FIRST);
    wb(1'b1, CWR_IDX_WSV, CWR_SEQ_SECOND);
  endtask
  // pulses seen in a window on the monitor (m) or watchdog reset
  task automatic win(input int c, input bit m, input bit e);
    repeat (c) @(posedge ref_clk);
    chk({31'h0, (m ? (mrCnt != mrBase) : (wdCnt != wdBase))}, {31'h0, e});
    wdBase = wdCnt;
    mrBase = mrCnt;
  endtask
  task automatic tmo(input int lim, input bit e);
    n = 0;
    while (periodicInterrupt !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, n < lim}, {31'h0, e});
  endtask
  task automatic ben(input int c, input int e);
    int h;
    h = 0;
    repeat (c) begin
      @(posedge ref_clk);
      h += int'(busClkEn === 1'b1);
    end
    chk(h, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    {wbCyc, wbStb, wbWe, specialMode, waitMode, debugActive, clockFail} = 7'h00;
    wbAdr = 6'h00;
    wbDat = 32'h0;
    void'($urandom(32'h33fb));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(CWR_IDX_PIC, CWR_PIC_RST);
    rd(CWR_IDX_WMC, CWR_WMC_RST);
    rd(CWR_IDX_SLOW, CWR_SLOW_RST);
    rd(CWR_IDX_WSV, 8'h00);
    rd(4'h9, 8'h00);
    wb(1'b1, CWR_IDX_WSV, CWR_SEQ_SECOND);
    win(20, 1'b0, 1'b0);
    svc();
    b = 8'($urandom_range(0, 255));
    if (b == CWR_SEQ_FIRST || b == CWR_SEQ_SECOND) b = 8'h00;
    wb(1'b1, CWR_IDX_WSV, b);
    win(10, 1'b0, 1'b1);
    svc();
    win(8000, 1'b0, 1'b0);
    svc();
    win(8000, 1'b0, 1'b0);
    win(400, 1'b0, 1'b1);
    svc();
    specialMode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b1, CWR_IDX_WMC, 8'h09);
    wb(1'b1, CWR_IDX_WSV, b);
    win(10, 1'b0, 1'b0);
    wb(1'b1, CWR_IDX_WMC, 8'h19);
    win(10, 1'b0, 1'b0);
    wb(1'b1, CWR_IDX_WMC, 8'h01);
    wb(1'b1, CWR_IDX_WMC, 8'h11);
    win(10, 1'b0, 1'b1);
    wb(1'b1, CWR_IDX_WMC, 8'h88);
    wb(1'b1, CWR_IDX_WMC, 8'ha8);
    win(10, 1'b1, 1'b0);
    wb(1'b1, CWR_IDX_WMC, 8'h80);
    wb(1'b1, CWR_IDX_WMC, 8'ha0);
    win(10, 1'b1, 1'b1);
    rd(CWR_IDX_WMC, 8'h80);
    for (int c = 1; c < 8; c++) begin
      wb(1'b1, CWR_IDX_PIC, 8'h88 | 8'(c));
      wb(1'b1, CWR_IDX_PIF, 8'h80);
      tmo((1 << (c + 1)) + 16, 1'b1);
    end
    rd(CWR_IDX_PIF, 8'h80);
    wb(1'b1, CWR_IDX_PIC, 8'h08);
    chk({31'h0, periodicInterrupt}, 32'h0);
    wb(1'b1, CWR_IDX_PIF, 8'h80);
    repeat (300) @(posedge ref_clk);
    rd(CWR_IDX_PIF, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, CWR_IDX_PIC, k ? 8'ha9 : 8'hc9);
      waitMode <= !k;
      debugActive <= k[0];
      repeat (4) @(posedge ref_clk);
      wb(1'b1, CWR_IDX_PIF, 8'h80);
      tmo(200, 1'b0);
      waitMode <= 1'b0;
      debugActive <= 1'b0;
      tmo(40, 1'b1);
    end
    s = $urandom_range(1, 7);
    wb(1'b1, CWR_IDX_SLOW, 8'(s));
    rd(CWR_IDX_SLOW, 8'(s));
    waitMode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ben(1024, 1024 >> s);
    waitMode <= 1'b0;
    repeat (8) @(posedge ref_clk);
    ben(64, 64);
    wb(1'b1, CWR_IDX_PIC, 8'h00);
    specialMode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wb(1'b1, CWR_IDX_PIC, 8'h08);
    rd(CWR_IDX_PIC, 8'h00);
    wb(1'b1, CWR_IDX_WMC, 8'h40);
    wb(1'b1, CWR_IDX_WMC, 8'h00);
    rd(CWR_IDX_WMC, 8'h40);
    chk({31'h0, monitorActive}, 32'h1);
    wb(1'b1, CWR_IDX_WMC, 8'h20);
    win(10, 1'b1, 1'b0);
    clockFail <= 1'b1;
    win(12, 1'b1, 1'b1);
    clockFail <= 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire
